//--- core/sta_alert_hold.sv
// one alert channel: assert on fault, hold timer on clear, restart on refault
`timescale 1ns/100ps
`default_nettype none
`include "sta_consts.svh"
module sta_alert_hold
  import sta_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      force_clr,
  input  wire logic      fault,
  input  wire logic      clear_ok,
  input  wire sta_hold_t hold_cycles,
  output logic           alert_n
);
  sta_alert_e st_r, st_nxt;
  sta_hold_t  cnt_r, cnt_nxt;
  logic       alert_n_nxt;

  // fault asserts; clear starts timer; refault restarts it
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    alert_n_nxt = alert_n;
    case (st_r)
      STA_IDLE: begin
        if (fault) begin
          st_nxt      = STA_ASSERT;
          alert_n_nxt = 1'b0;
        end
      end
      STA_ASSERT: begin
        if (!fault && clear_ok) begin
          if (hold_cycles == '0) begin
            st_nxt      = STA_IDLE;
            alert_n_nxt = 1'b1;
          end else begin
            st_nxt  = STA_HOLDING;
            cnt_nxt = hold_cycles - 24'h00_0001;
          end
        end
      end
      STA_HOLDING: begin
        if (fault || !clear_ok) begin
          st_nxt = STA_ASSERT;
        end else if (cnt_r == '0) begin
          st_nxt      = STA_IDLE;
          alert_n_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 24'h00_0001;
        end
      end
      default: begin
        st_nxt      = STA_IDLE;
        alert_n_nxt = 1'b1;
      end
    endcase
    // lockout forces the channel back to idle
    if (force_clr) begin
      st_nxt      = STA_IDLE;
      cnt_nxt     = '0;
      alert_n_nxt = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r    <= STA_IDLE;
      cnt_r   <= '0;
      alert_n <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      alert_n <= alert_n_nxt;
    end
  end
endmodule : sta_alert_hold
`default_nettype wire

//--- core/sta_consts.svh
// constants of the supply and temperature alert logic
// How it works
// - floating polarity pin makes both thresholds overtemperature; sensor pin high uses internal only
// - dual overtemperature: first alert at first threshold, second at second threshold
// - temperature alert releases only after hold timeout once temperature is back
// - undervoltage alert low whenever either high tap is below trip level
// - overvoltage alert low whenever either low tap is above trip level outside lockout
// - during power-up lockout: undervoltage low, other alerts released high
// - supply valid: comparisons take control, hold timer releases undervoltage alert
// - supply drop re-enters lockout: undervoltage low, overvoltage cleared
// - each supply tap comparator result is integrated before it acts
// - temperature alert only after five consecutive intervals beyond threshold
// - release after one interval past hysteresis plus the hold delay
// - outside lockout, every alert stays asserted for the hold timeout after its fault clears
// - undervoltage timer starts only when all high taps are good
// - any high tap failing during hold resets timer until all good again
// - overtemperature hold timer starts when below threshold minus hysteresis
// - polarity pin high: under then over; floating: both over; low: both under
// - sensor pin floating: first threshold internal only, second external only
`ifndef STA_CONSTS_SVH
`define STA_CONSTS_SVH
`define STA_TEMP_DEBOUNCE   3'h5
`define STA_FILT_MAX        4'h8
`define STA_FILT_ON         4'h6
`define STA_FILT_OFF        4'h2
`define STA_HOLD_W          24
`define STA_TRI_LOW         2'h0
`define STA_TRI_HIGH        2'h1
`define STA_TRI_OPEN        2'h2
`endif

//--- core/sta_pkg.sv
// types of the supply and temperature alert logic
package sta_pkg;
  typedef logic [1:0] sta_tri_t;
  typedef logic [23:0] sta_hold_t;
  typedef enum logic [1:0] {
    STA_IDLE    = 2'b00,
    STA_ASSERT  = 2'b01,
    STA_HOLDING = 2'b11
  } sta_alert_e;
endpackage : sta_pkg

//--- core/sta_top.sv
// alert logic of a dual supply and temperature supervisor
`timescale 1ns/100ps
`default_nettype none
`include "sta_consts.svh"
module sta_top
  import sta_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      supply_valid,
  input  wire logic      supply1_high_tap,
  input  wire logic      supply2_high_tap,
  input  wire logic      supply1_low_tap,
  input  wire logic      supply2_low_tap,
  input  wire logic      conv_tick,
  input  wire logic      conv_is_external,
  input  wire logic      temp_above_first,
  input  wire logic      temp_below_first,
  input  wire logic      temp_above_second,
  input  wire logic      temp_below_second,
  input  wire sta_tri_t  polarity_select_pin,
  input  wire sta_tri_t  sensor_select_pin,
  input  wire sta_hold_t alert_hold_time,
  output logic           under_supply_alert_n,
  output logic           over_supply_alert_n,
  output logic           first_temp_alert_n,
  output logic           second_temp_alert_n
);
  // taps: high tap 1 means above 0.5 V; low tap 1 means above 0.5 V
  // temp: above_x means over x, below_x means under x minus hysteresis,
  // and mirror-image for undertemperature via the same two flags

  // two-flop synchronisers for every analog comparator result
  localparam int NS = 11;
  logic [NS-1:0] in_raw, s1_r, s2_r;
  assign in_raw = {supply_valid, supply1_high_tap, supply2_high_tap, supply1_low_tap,
                   supply2_low_tap, conv_tick, conv_is_external, temp_above_first,
                   temp_below_first, temp_above_second, temp_below_second};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= in_raw;
      s2_r <= s1_r;
    end
  end
  logic vok, h1, h2, l1, l2, tick_lvl, ext, a1, b1, a2, b2;
  assign {vok, h1, h2, l1, l2, tick_lvl, ext, a1, b1, a2, b2} = s2_r;

  // integrating filter with hysteresis on the count; a one-cycle glitch
  // moves the count by one only, so a real fault costs some latency but
  // the trip point itself carries no hysteresis error
  function automatic logic [4:0] filt_step(input logic [3:0] c, input logic o, input logic x);
    logic [3:0] n;
    logic       no;
    n  = x ? ((c == `STA_FILT_MAX) ? c : c + 4'h1) : ((c == 4'h0) ? c : c - 4'h1);
    no = o;
    if (n >= `STA_FILT_ON) no = 1'b1;
    else if (n <= `STA_FILT_OFF) no = 1'b0;
    return {no, n};
  endfunction : filt_step

  // supply comparator integration
  // order of fin: high tap 1, high tap 2, low tap 1, low tap 2
  logic [3:0] fc_r [4];
  logic [3:0] fc_nxt [4];
  logic [3:0] fo_r, fo_nxt, fin;
  assign fin = {!h1, !h2, l1, l2};
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      {fo_nxt[i], fc_nxt[i]} = filt_step(fc_r[i], fo_r[i], fin[i]);
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) fc_r[i] <= 4'h0;
      fo_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) fc_r[i] <= fc_nxt[i];
      fo_r <= fo_nxt;
    end
  end
  logic uv_fault, ov_fault, lockout;
  assign uv_fault = fo_r[3] | fo_r[2];
  assign ov_fault = fo_r[1] | fo_r[0];
  assign lockout  = !vok;

  // strap pins pass their own two flops before the decode reads them;
  // straps are meant to be static, so a two-bit code caught half-way
  // through a change shows for one cycle only, between ticks
  sta_tri_t pol_s1_r, pol_s2_r, sel_s1_r, sel_s2_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pol_s1_r <= `STA_TRI_OPEN;
      pol_s2_r <= `STA_TRI_OPEN;
      sel_s1_r <= `STA_TRI_HIGH;
      sel_s2_r <= `STA_TRI_HIGH;
    end else begin
      pol_s1_r <= polarity_select_pin;
      pol_s2_r <= pol_s1_r;
      sel_s1_r <= sensor_select_pin;
      sel_s2_r <= sel_s1_r;
    end
  end

  // conversion strobe edge, polarity and sensor decode
  logic tick_d_r, tick;
  logic ut1, ut2, use1, use2;
  assign tick = tick_lvl & !tick_d_r;
  always_comb begin
    case (pol_s2_r)
      `STA_TRI_HIGH: begin ut1 = 1'b1; ut2 = 1'b0; end
      `STA_TRI_LOW:  begin ut1 = 1'b1; ut2 = 1'b1; end
      default:       begin ut1 = 1'b0; ut2 = 1'b0; end
    endcase
    // alternating sensors tie each threshold to one sensor
    if (sel_s2_r == `STA_TRI_OPEN) begin
      use1 = !ext;
      use2 = ext;
    end else begin
      use1 = 1'b1;
      use2 = 1'b1;
    end
  end

  // pick the flag that applies to a threshold of the given direction
  function automatic logic pick(input logic under, input logic for_under, input logic for_over);
    return under ? for_under : for_over;
  endfunction : pick

  // five-interval debounce and hysteresis release per temperature channel
  logic [2:0] tc_r [2];
  logic [2:0] tc_nxt [2];
  logic [1:0] tf_r, tf_nxt, tclr_r, tclr_nxt;
  logic [1:0] beyond, back;
  // fault: over the threshold, or under it minus hysteresis for undertemp
  assign beyond = {pick(ut2, b2, a2), pick(ut1, b1, a1)};
  // back means past threshold by the hysteresis; the front end encodes that
  assign back   = {pick(ut2, a2, b2), pick(ut1, a1, b1)};
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tc_nxt[i]   = tc_r[i];
      tf_nxt[i]   = tf_r[i];
      tclr_nxt[i] = tclr_r[i];
      if (tick && (i == 0 ? use1 : use2)) begin
        if (beyond[i]) begin
          tc_nxt[i]   = (tc_r[i] == `STA_TEMP_DEBOUNCE) ? tc_r[i] : tc_r[i] + 3'h1;
          tclr_nxt[i] = 1'b0;
          if (tc_r[i] + 3'h1 >= `STA_TEMP_DEBOUNCE) tf_nxt[i] = 1'b1;
        end else begin
          tc_nxt[i] = 3'h0;
          // one interval past hysteresis lets the hold timer start
          if (back[i] && tf_r[i]) begin
            tf_nxt[i]   = 1'b0;
            tclr_nxt[i] = 1'b1;
          end
        end
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_d_r <= 1'b0;
      tc_r[0]  <= 3'h0;
      tc_r[1]  <= 3'h0;
      tf_r     <= 2'h0;
      tclr_r   <= 2'h3;
    end else begin
      tick_d_r <= tick_lvl;
      tc_r[0]  <= tc_nxt[0];
      tc_r[1]  <= tc_nxt[1];
      tf_r     <= tf_nxt;
      tclr_r   <= tclr_nxt;
    end
  end

  // power-up lockout: undervoltage held low, others released
  // lockout is itself an undervoltage fault, so it needs no forced clear
  logic uv_src, all_high;
  assign uv_src   = lockout | uv_fault;
  assign all_high = vok & !fo_r[3] & !fo_r[2];

  // one shared-setting hold channel per alert
  // the hold setting is read without synchronisers: it must stay static,
  // a change in mid-hold leaves the running timeout alone and applies from the next timer start
  sta_alert_hold u_uv (
    .mclk        (mclk),
    .rst         (rst),
    .force_clr   (1'b0),
    .fault       (uv_src),
    .clear_ok    (all_high),
    .hold_cycles (alert_hold_time),
    .alert_n     (under_supply_alert_n)
  );
  sta_alert_hold u_ov (
    .mclk        (mclk),
    .rst         (rst),
    .force_clr   (lockout),
    .fault       (ov_fault & vok),
    .clear_ok    (1'b1),
    .hold_cycles (alert_hold_time),
    .alert_n     (over_supply_alert_n)
  );
  sta_alert_hold u_t1 (
    .mclk        (mclk),
    .rst         (rst),
    .force_clr   (lockout),
    .fault       (tf_r[0]),
    .clear_ok    (tclr_r[0]),
    .hold_cycles (alert_hold_time),
    .alert_n     (first_temp_alert_n)
  );
  sta_alert_hold u_t2 (
    .mclk        (mclk),
    .rst         (rst),
    .force_clr   (lockout),
    .fault       (tf_r[1]),
    .clear_ok    (tclr_r[1]),
    .hold_cycles (alert_hold_time),
    .alert_n     (second_temp_alert_n)
  );
endmodule : sta_top
`default_nettype wire

//--- tb/sta_properties.sv
// port checker for the supply and temperature alert logic
`timescale 1ns/100ps
`default_nettype none
`include "sta_consts.svh"
module sta_checker
  import sta_pkg::*;
(
  input wire logic      mclk,
  input wire logic      rst,
  input wire logic      supply_valid,
  input wire logic      supply1_high_tap,
  input wire logic      supply2_high_tap,
  input wire logic      supply1_low_tap,
  input wire logic      supply2_low_tap,
  input wire logic      temp_above_first,
  input wire sta_tri_t  polarity_select_pin,
  input wire sta_hold_t alert_hold_time,
  input wire logic      under_supply_alert_n,
  input wire logic      over_supply_alert_n,
  input wire logic      first_temp_alert_n,
  input wire logic      second_temp_alert_n
);
  logic       ok;
  logic [7:0] good_r, ovok_r, vld_r, quiet_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  assign ok = supply_valid && supply1_high_tap && supply2_high_tap;
  function automatic logic [7:0] run(input logic c, input logic [7:0] v);
    return c ? v + {7'h00, ~&v} : 8'h00;
  endfunction : run
  // saturating run lengths; only meaningful for hold settings below 255
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {good_r, ovok_r, vld_r, quiet_r} <= 32'h0000_0000;
    end else begin
      good_r  <= run(ok, good_r);
      ovok_r  <= run(!supply1_low_tap && !supply2_low_tap, ovok_r);
      vld_r   <= run(supply_valid, vld_r);
      quiet_r <= run(!temp_above_first, quiet_r);
    end
  end
  a_lockout_under: assert property ((!supply_valid)[*5] |-> !under_supply_alert_n)
    else $error("under alert high in lockout");
  a_lockout_clears: assert property ((!supply_valid)[*5] |->
    over_supply_alert_n && first_temp_alert_n && second_temp_alert_n)
    else $error("alert low in lockout");
  a_under_fault: assert property ((supply_valid && !supply1_high_tap)[*8] |->
    ##[1:6] !under_supply_alert_n)
    else $error("under alert missing");
  a_over_fault: assert property ((supply_valid && supply2_low_tap)[*8] |->
    ##[1:6] !over_supply_alert_n)
    else $error("over alert missing");
  a_glitch_filtered: assert property ((ok && under_supply_alert_n)[*8] ##1
    (supply_valid && !supply1_high_tap) ##1 ok[*8] |-> under_supply_alert_n)
    else $error("glitch reached under alert");
  a_under_hold: assert property ($rose(under_supply_alert_n) |->
    {16'h0000, good_r} > alert_hold_time)
    else $error("under alert released early");
  a_over_hold: assert property ($rose(over_supply_alert_n) && vld_r > 8'h08 |->
    {16'h0000, ovok_r} > alert_hold_time)
    else $error("over alert released early");
  a_temp_debounce: assert property (polarity_select_pin == `STA_TRI_OPEN &&
    quiet_r > 8'h28 |-> !$fell(first_temp_alert_n))
    else $error("temp alert without fault");
endmodule : sta_checker
bind sta_top sta_checker sta_checker_inst (.mclk, .rst, .supply_valid, .supply1_high_tap,
  .supply2_high_tap, .supply1_low_tap, .supply2_low_tap, .temp_above_first,
  .polarity_select_pin, .alert_hold_time, .under_supply_alert_n, .over_supply_alert_n,
  .first_temp_alert_n, .second_temp_alert_n);
`default_nettype wire

//--- tb/sta_sensor_model.sv
// behavioural temperature sensor: conversion strobe and threshold flags
`timescale 1ns/100ps
`default_nettype none
`include "sta_consts.svh"
module sta_sensor_model
  import sta_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] temperature_level,
  input  wire sta_tri_t   sensor_select_pin,
  output logic            conv_tick,
  output logic            conv_is_external,
  output logic            temp_above_first,
  output logic            temp_below_first,
  output logic            temp_above_second,
  output logic            temp_below_second
);
  logic [2:0] phase_r;
  logic       ext_r;
  // one conversion each eight cycles, strobe two wide so the synchroniser sees it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_r <= 3'h0;
      ext_r   <= 1'b0;
    end else begin
      phase_r <= phase_r + 3'h1;
      if (phase_r == 3'h0) ext_r <= (sensor_select_pin == `STA_TRI_OPEN) & ~ext_r;
    end
  end
  // both sensors read one level; thresholds 0x40 and 0x60, hysteresis 4
  assign conv_tick         = phase_r[2] & ~phase_r[1];
  assign conv_is_external  = ext_r;
  assign temp_above_first  = temperature_level > 8'h40;
  assign temp_below_first  = temperature_level < 8'h3c;
  assign temp_above_second = temperature_level > 8'h60;
  assign temp_below_second = temperature_level < 8'h5c;
endmodule : sta_sensor_model
`default_nettype wire

//--- tb/tb_supply_temp_alert_logic.sv
// self-checking bench for the supply and temperature alert logic
`timescale 1ns/100ps
`default_nettype none
`include "sta_consts.svh"
module tb_supply_temp_alert_logic;
  import sta_pkg::*;
  localparam sta_hold_t HOLD = 24'h00_0014;
  logic       mclk, rst, supply_valid, conv_tick, conv_is_external;
  logic       supply1_high_tap, supply2_high_tap, supply1_low_tap, supply2_low_tap;
  logic       temp_above_first, temp_below_first, temp_above_second, temp_below_second;
  logic       under_supply_alert_n, over_supply_alert_n, first_temp_alert_n;
  logic       second_temp_alert_n;
  sta_tri_t   polarity_select_pin, sensor_select_pin;
  sta_hold_t  alert_hold_time;
  logic [7:0] temperature_level;
  logic [3:0] al;
  int         fail_count, tests_run, cycles, n;
  assign al = {second_temp_alert_n, first_temp_alert_n, over_supply_alert_n,
               under_supply_alert_n};
  sta_top sta_top_inst (.*);
  sta_sensor_model sta_sensor_model_inst (.*);
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t saw %b expected %b", $time, seen, exp);
    end
  endtask : chk
  // inputs always move 2 ns after the rising edge
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask : cyc
  task automatic ticks(input int k);
    repeat (k) @(posedge conv_tick);
    cyc(6);
  endtask : ticks
  // bounded wait for an alert to release, n counts the cycles
  task automatic rise(input int s);
    n = 0;
    while (al[s] !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
  endtask : rise
  // hang guard, far above the roughly 600 cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {rst, supply_valid, supply1_high_tap, supply2_high_tap} = 4'b1011;
    {supply1_low_tap, supply2_low_tap} = 2'b00;
    polarity_select_pin = `STA_TRI_OPEN;
    sensor_select_pin   = `STA_TRI_HIGH;
    alert_hold_time     = HOLD;
    temperature_level   = 8'h30;
    cyc(2);
    rst = 1'b0;
    cyc(6);
    chk(al === 4'b1110, 1'b1);
    supply_valid = 1'b1;
    rise(0);
    chk(n > HOLD && n < HOLD + 16, 1'b1);
    // one-cycle dip after a quiet spell must not reach the output
    cyc(10);
    supply1_high_tap = 1'b0;
    cyc(1);
    supply1_high_tap = 1'b1;
    cyc(12);
    chk(al[0], 1'b1);
    supply2_high_tap = 1'b0;
    cyc(14);
    chk(al[0], 1'b0);
    // refault in mid-hold restarts the timer
    supply2_high_tap = 1'b1;
    cyc(12);
    supply1_high_tap = 1'b0;
    // look past the point where an unrestarted timer would have let go
    cyc(24);
    chk(al[0], 1'b0);
    supply1_high_tap = 1'b1;
    rise(0);
    chk(n > HOLD && n < HOLD + 16, 1'b1);
    supply1_low_tap = 1'b1;
    cyc(14);
    chk(al[1], 1'b0);
    supply1_low_tap = 1'b0;
    rise(1);
    chk(n > HOLD && n < HOLD + 16, 1'b1);
    // supply loss with overvoltage pending
    supply2_low_tap = 1'b1;
    cyc(14);
    supply_valid = 1'b0;
    cyc(5);
    chk(al[1:0] === 2'b10, 1'b1);
    {supply2_low_tap, supply_valid} = 2'b01;
    rise(0);
    // four intervals beyond the threshold are not enough, five are
    ticks(1);
    temperature_level = 8'h50;
    ticks(4);
    chk(al[2], 1'b1);
    ticks(1);
    chk(al[2], 1'b0);
    temperature_level = 8'h70;
    ticks(6);
    chk(al[3], 1'b0);
    temperature_level = 8'h30;
    rise(2);
    chk(n > HOLD && n < HOLD + 16, 1'b1);
    rise(3);
    polarity_select_pin = `STA_TRI_LOW;
    ticks(6);
    chk(al[3:2] === 2'b00, 1'b1);
    polarity_select_pin = `STA_TRI_OPEN;
    rise(2);
    rise(3);
    // alternate sensors: first threshold counts only internal conversions
    sensor_select_pin = `STA_TRI_OPEN;
    ticks(1);
    temperature_level = 8'h50;
    ticks(7);
    chk(al[2], 1'b1);
    ticks(4);
    chk(al[2], 1'b0);
    // polarity high: first is undertemperature, second overtemperature
    sensor_select_pin   = `STA_TRI_HIGH;
    polarity_select_pin = `STA_TRI_HIGH;
    temperature_level   = 8'h70;
    ticks(6);
    chk(al[3:2] === 2'b01, 1'b1);
    complete_run();
  end
endmodule : tb_supply_temp_alert_logic
`default_nettype wire
